// ===== pin_model.sv
/*
 * Partner model of the eight external port pins, each with a pull-up.
 * Assumes the block's pin value and enable, plus a bench pull-down request.
 */
`timescale 1ns/1ps
module pin_model (
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] drv_en_i,
    input  wire logic [7:0] ext_low_i,
    output logic      [7:0] pin_level_o
);
    // A driven pin shows the block's value; a released one floats to the pull-up unless the bench pulls it low.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (drv_en_i[i]) begin
                pin_level_o[i] = drv_i[i];
            end else begin
                pin_level_o[i] = ~ext_low_i[i];
            end
        end
    end
endmodule // pin_model

// ===== pin_sync.sv
/*
 * Two-stage synchroniser for the eight port pins.
 * Assumes pins are asynchronous to sys_clk_i.
 */
`timescale 1ns/1ps
module pin_sync
    import port_io_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [7:0] pin_i,
    output logic      [7:0] pin_sync_o
);
    typedef struct packed {
        logic [7:0] meta;
        logic [7:0] sync;
    } sync_s;
    sync_s st_ff;
    sync_s nxt_st;

    // The first stage feeds only the second stage.
    always_comb begin
        nxt_st.meta = pin_i;
        nxt_st.sync = st_ff.meta;
    end

    // Pins idle high through weak pull-ups, so reset to ones.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff <= '{meta: PIN_IDLE, sync: PIN_IDLE};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pin_sync_o = st_ff.sync;
endmodule // pin_sync

// ===== port_io_latch_and_routing.sv
/*
 * Port 0 data latch, output-mode register and peripheral routing register.
 * Assumes the core drives the register strobes on sys_clk_i and takes read data
 * from a register one cycle after the read strobe.
 */
`timescale 1ns/1ps
module port_io_latch_and_routing
    import port_io_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic       sfr_rmw_i,
    input  wire logic       sfr_bit_i,
    input  wire logic [2:0] sfr_bit_sel_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic [7:0] pin_i,
    output logic      [7:0] pin_o,
    output logic      [7:0] pin_oe_o,
    input  wire logic       uart_tx_i,
    input  wire logic       timer0_i,
    input  wire logic       timer1_i,
    input  wire logic       timer2_i,
    output logic            uart_rx_o,
    output logic            timer2_ext_input_o,
    output logic            ext_irq0_pin_o,
    output logic            ext_irq1_pin_o,
    output logic      [7:0] route_enable_o
);
    typedef struct packed {
        logic [7:0] port0_data_latch;
        logic [7:0] peripheral_route_enable_0;
        logic [7:0] port0_output_mode;
        logic [7:0] rdata;
    } port_s;
    port_s st_ff;
    port_s nxt_st;
    logic [7:0] pin_s;
    logic [7:0] drv_val;
    logic [7:0] drv_push;

    // Merge one addressed bit into a byte; used only for bit writes to the port latch.
    function automatic logic [7:0] merge_bit(input logic [7:0] base, input logic [2:0] sel,
                                             input logic val);
        logic [7:0] r;
        r = base;
        r[sel] = val;
        return r;
    endfunction

    pin_sync u_sync (
        .sys_clk_i  (sys_clk_i),
        .arst_n_i   (arst_n_i),
        .pin_i      (pin_i),
        .pin_sync_o (pin_s)
    );

    // Register updates and registered read data.
    always_comb begin
        nxt_st = st_ff;
        if (sfr_wr_i) begin
            unique case (sfr_addr_i)
                SFR_PORT0: begin
                    // Bit writes keep the other bits from the latch, never the pins.
                    if (sfr_bit_i) begin
                        nxt_st.port0_data_latch = merge_bit(st_ff.port0_data_latch,
                            sfr_bit_sel_i, sfr_wdata_i[0]);
                    end else begin
                        nxt_st.port0_data_latch = sfr_wdata_i;
                    end
                end
                SFR_ROUTE0: begin
                    nxt_st.peripheral_route_enable_0 = sfr_wdata_i & ROUTE0_WMASK;
                end
                SFR_OUT_MODE0: begin
                    nxt_st.port0_output_mode = sfr_wdata_i;
                end
                default: begin
                end
            endcase
        end
        nxt_st.rdata = 8'h00;
        if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                SFR_PORT0: begin
                    // Read-modify-write sees the latch; plain reads see the pins.
                    nxt_st.rdata = sfr_rmw_i ? st_ff.port0_data_latch : pin_s;
                end
                SFR_ROUTE0:    nxt_st.rdata = st_ff.peripheral_route_enable_0;
                SFR_OUT_MODE0: nxt_st.rdata = st_ff.port0_output_mode;
                default:       nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff <= '{port0_data_latch: PORT0_RESET,
                       peripheral_route_enable_0: ROUTE0_RESET,
                       port0_output_mode: OUT_MODE_RESET,
                       rdata: RDATA_RESET};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Peripheral outputs override the latch on their claimed pins; inputs
    // such as receive or interrupt pins are forced high and open-drain to float.
    always_comb begin
        drv_val  = st_ff.port0_data_latch;
        drv_push = st_ff.port0_output_mode;
        if (st_ff.peripheral_route_enable_0[RT_UART]) begin
            drv_val[PIN_TX]  = uart_tx_i;
            drv_val[PIN_RX]  = 1'b1;
            drv_push[PIN_RX] = 1'b0;
        end
        if (st_ff.peripheral_route_enable_0[RT_T0])   drv_val[PIN_T0] = timer0_i;
        if (st_ff.peripheral_route_enable_0[RT_T1])   drv_val[PIN_T1] = timer1_i;
        if (st_ff.peripheral_route_enable_0[RT_T2])   drv_val[PIN_T2] = timer2_i;
        if (st_ff.peripheral_route_enable_0[RT_IRQ0]) begin
            drv_val[PIN_IRQ0]  = 1'b1;
            drv_push[PIN_IRQ0] = 1'b0;
        end
        if (st_ff.peripheral_route_enable_0[RT_IRQ1]) begin
            drv_val[PIN_IRQ1]  = 1'b1;
            drv_push[PIN_IRQ1] = 1'b0;
        end
        if (st_ff.peripheral_route_enable_0[RT_TIMER2_EXT_INPUT]) begin
            drv_val[PIN_TIMER2_EXT_INPUT]  = 1'b1;
            drv_push[PIN_TIMER2_EXT_INPUT] = 1'b0;
        end
    end

    // A zero always drives; a one drives only in push-pull mode.
    assign pin_o    = drv_val;
    assign pin_oe_o = ~drv_val | drv_push;

    // Routed inputs read high (inactive) when their route is disabled.
    assign uart_rx_o          = st_ff.peripheral_route_enable_0[RT_UART] ? pin_s[PIN_RX] : 1'b1;
    assign ext_irq0_pin_o     = st_ff.peripheral_route_enable_0[RT_IRQ0] ? pin_s[PIN_IRQ0] : 1'b1;
    assign ext_irq1_pin_o     = st_ff.peripheral_route_enable_0[RT_IRQ1] ? pin_s[PIN_IRQ1] : 1'b1;
    assign timer2_ext_input_o = st_ff.peripheral_route_enable_0[RT_TIMER2_EXT_INPUT] ? pin_s[PIN_TIMER2_EXT_INPUT] : 1'b1;
    assign route_enable_o     = st_ff.peripheral_route_enable_0;
    assign sfr_rdata_o        = st_ff.rdata;

    property p_byte_write;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (sfr_wr_i && !sfr_bit_i && sfr_addr_i == SFR_PORT0) |=>
            st_ff.port0_data_latch == $past(sfr_wdata_i);
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("Port byte write not latched.");

    property p_latch_hold;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        !(sfr_wr_i && sfr_addr_i == SFR_PORT0) |=> $stable(st_ff.port0_data_latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("Latch changed without write.");

    property p_pin_read;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (sfr_rd_i && !sfr_rmw_i && sfr_addr_i == SFR_PORT0) |=> sfr_rdata_o == $past(pin_s);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("Plain read did not return pins.");

    property p_rmw_read;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (sfr_rd_i && sfr_rmw_i && sfr_addr_i == SFR_PORT0) |=>
            sfr_rdata_o == $past(st_ff.port0_data_latch);
    endproperty
    a_rmw_read: assert property (p_rmw_read) else $error("RMW read did not return latch.");

    property p_bit_write;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (sfr_wr_i && sfr_bit_i && sfr_addr_i == SFR_PORT0) |=>
            st_ff.port0_data_latch[$past(sfr_bit_sel_i)] == $past(sfr_wdata_i[0]);
    endproperty
    a_bit_write: assert property (p_bit_write) else $error("Port bit write lost.");

    property p_drive_low;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (route_enable_o == 8'h00 && !st_ff.port0_data_latch[0]) |-> pin_oe_o[0] && !pin_o[0];
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("Latched zero not driven low.");

    property p_open_drain;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (route_enable_o == 8'h00 && st_ff.port0_data_latch[1]) |->
            pin_oe_o[1] == st_ff.port0_output_mode[1];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("Output mode not honoured.");

    property p_tx_route;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        route_enable_o[RT_UART] |-> pin_o[PIN_TX] == uart_tx_i;
    endproperty
    a_tx_route: assert property (p_tx_route) else $error("Routed transmit not on pin.");

    // A route write is the first step of both route checks below.
    sequence s_route_write;
        sfr_wr_i && sfr_addr_i == SFR_ROUTE0;
    endsequence

    // The unused bit must stay clear even if software writes ones to it.
    property p_route_bit1;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        s_route_write |=> !route_enable_o[1] ##1 !route_enable_o[1];
    endproperty
    a_route_bit1: assert property (p_route_bit1) else $error("Unused route bit set.");

    property p_route_write;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        s_route_write |=> route_enable_o == ($past(sfr_wdata_i) & ROUTE0_WMASK);
    endproperty
    a_route_write: assert property (p_route_write) else $error("Route write not applied.");

    // Read data returns to its idle value once the strobe is gone.
    property p_rdata_idle;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        !sfr_rd_i |=> sfr_rdata_o == RDATA_RESET;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("Read data not idle.");

    property p_timer_route;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        route_enable_o[RT_T1] |-> pin_o[PIN_T1] == timer1_i;
    endproperty
    a_timer_route: assert property (p_timer_route) else $error("Routed timer not on pin.");

    // A routed input pin must be released so the outside can drive it.
    property p_input_release;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        route_enable_o[RT_IRQ1] |-> !pin_oe_o[PIN_IRQ1];
    endproperty
    a_input_release: assert property (p_input_release) else $error("Input pin driven.");

    property p_unrouted_input;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        !route_enable_o[RT_TIMER2_EXT_INPUT] |-> timer2_ext_input_o;
    endproperty
    a_unrouted_input: assert property (p_unrouted_input) else $error("Unrouted input low.");
endmodule // port_io_latch_and_routing

// ===== port_io_pkg.sv
/*
 * Constants for the 8-bit general-purpose port with peripheral routing.
 * Assumes an 8-bit special-function register bus with byte and bit access.
 */
// Contract
// - Written port value held in latch.
// - Normal read returns pin levels.
// - Read-modify-write reads latch, not pins.
// - Bit move, clear, set use latch.
// - Port is byte and bit addressable.
// - Zero drives low; one per output mode.
// - Enabled peripheral signals override latched values.
// - Route register bits enable peripheral signals.
// - Output-mode bit zero open-drain, one push-pull.
package port_io_pkg;
    localparam logic [7:0] SFR_PORT0      = 8'h80;
    localparam logic [7:0] SFR_ROUTE0     = 8'hE1;
    localparam logic [7:0] SFR_OUT_MODE0  = 8'hA4;
    localparam logic [7:0] PORT0_RESET    = 8'hFF;
    localparam logic [7:0] ROUTE0_RESET   = 8'h00;
    localparam logic [7:0] OUT_MODE_RESET = 8'h00;
    localparam logic [7:0] ROUTE0_WMASK   = 8'hFD;
    // Synchroniser value after reset, matching the pulled-up idle pins.
    localparam logic [7:0] PIN_IDLE       = 8'hFF;
    // Read data after reset and whenever no read strobe is present.
    localparam logic [7:0] RDATA_RESET    = 8'h00;
    // Route register field positions.
    localparam int unsigned RT_TIMER2_EXT_INPUT  = 7;
    localparam int unsigned RT_T2    = 6;
    localparam int unsigned RT_T1    = 5;
    localparam int unsigned RT_T0    = 4;
    localparam int unsigned RT_IRQ1  = 3;
    localparam int unsigned RT_IRQ0  = 2;
    localparam int unsigned RT_UART  = 0;
    // Fixed pin assignment of the routed peripheral signals.
    localparam int unsigned PIN_TX   = 0;
    localparam int unsigned PIN_RX   = 1;
    localparam int unsigned PIN_T0   = 2;
    localparam int unsigned PIN_IRQ0 = 3;
    localparam int unsigned PIN_T1   = 4;
    localparam int unsigned PIN_IRQ1 = 5;
    localparam int unsigned PIN_T2   = 6;
    localparam int unsigned PIN_TIMER2_EXT_INPUT = 7;
endpackage

// ===== tb_port_io_latch_and_routing.sv
/*
 * Self-checking bench for the port latch, output mode and routing register.
 * Assumes one-cycle strobes and read data registered one cycle after the read.
 */
`timescale 1ns/1ps
module tb_port_io_latch_and_routing;
    import port_io_pkg::*;
    logic       sys_clk_i = 1'b0;
    logic       arst_n_i  = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, ext_low = 8'h00, rv;
    logic       wr = 1'b0, rd = 1'b0, rmw = 1'b0, bitw = 1'b0;
    logic [2:0] sel = 3'h0;
    logic       tx = 1'b1, t0 = 1'b1, t1 = 1'b1, t2 = 1'b1;
    logic [7:0] rdata, pin_lvl, pin_o, pin_oe, route;
    logic       rx, timer2_ext_input, irq0, irq1;
    int         fails = 0;
    int         checked = 0;

    always #25 sys_clk_i = ~sys_clk_i;

    port_io_latch_and_routing u_port_io_latch_and_routing (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_rmw_i(rmw), .sfr_bit_i(bitw), .sfr_bit_sel_i(sel),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .pin_i(pin_lvl), .pin_o(pin_o),
        .pin_oe_o(pin_oe), .uart_tx_i(tx), .timer0_i(t0), .timer1_i(t1), .timer2_i(t2),
        .uart_rx_o(rx), .timer2_ext_input_o(timer2_ext_input), .ext_irq0_pin_o(irq0),
        .ext_irq1_pin_o(irq1), .route_enable_o(route));
    pin_model u_pin_model (.drv_i(pin_o), .drv_en_i(pin_oe), .ext_low_i(ext_low),
        .pin_level_o(pin_lvl));

    // Compares one value and reports a mismatch at once.
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Writes are one-cycle strobes launched at a falling edge.
    task automatic wr_sfr(input logic [7:0] a, input logic [7:0] d, input logic b,
                          input logic [2:0] s);
        @(negedge sys_clk_i);
        addr = a;
        wdata = d;
        bitw = b;
        sel = s;
        wr = 1'b1;
        @(negedge sys_clk_i);
        wr = 1'b0;
        bitw = 1'b0;
    endtask

    // Read data is registered, so it is sampled one falling edge later.
    task automatic rd_sfr(input logic [7:0] a, input logic m, output logic [7:0] d);
        @(negedge sys_clk_i);
        addr = a;
        rmw = m;
        rd = 1'b1;
        @(negedge sys_clk_i);
        d = rdata;
        rd = 1'b0;
        rmw = 1'b0;
    endtask

    // Ends the run with the verdict; also reached when the watchdog expires.
    task automatic tally_and_finish();
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Reset values, and read data falling back to idle once the strobe ends.
    task automatic t_reset();
        rd_sfr(SFR_PORT0, 1'b1, rv);
        check("latch", PORT0_RESET, rv);
        @(negedge sys_clk_i);
        check("rdata idle", RDATA_RESET, rdata);
        rd_sfr(SFR_ROUTE0, 1'b0, rv);
        check("route", ROUTE0_RESET, rv);
        check("oe", 8'h00, pin_oe);
        check("pin_o", PORT0_RESET, pin_o);
    endtask

    task automatic t_push();
        wr_sfr(SFR_PORT0, 8'h5A, 1'b0, 3'h0);
        wr_sfr(SFR_OUT_MODE0, 8'hFF, 1'b0, 3'h0);
        check("oe", 8'hFF, pin_oe);
        check("pins", 8'h5A, pin_lvl);
        repeat (3) @(negedge sys_clk_i);
        rd_sfr(SFR_PORT0, 1'b0, rv);
        check("read", 8'h5A, rv);
        rd_sfr(SFR_OUT_MODE0, 1'b0, rv);
        check("mode", 8'hFF, rv);
    endtask

    // Open drain: one pin released high is pulled low outside.
    task automatic t_open();
        wr_sfr(SFR_OUT_MODE0, 8'h00, 1'b0, 3'h0);
        ext_low = 8'h02;
        check("oe", 8'hA5, pin_oe);
        repeat (3) @(negedge sys_clk_i);
        rd_sfr(SFR_PORT0, 1'b0, rv);
        check("read", 8'h58, rv);
        rd_sfr(SFR_PORT0, 1'b1, rv);
        check("rmw", 8'h5A, rv);
    endtask

    task automatic t_bits();
        wr_sfr(SFR_PORT0, 8'h01, 1'b1, 3'h0);
        wr_sfr(SFR_PORT0, 8'h00, 1'b1, 3'h6);
        rd_sfr(SFR_PORT0, 1'b1, rv);
        check("bits", 8'h1B, rv);
        check("oe", 8'hE4, pin_oe);
    endtask

    // All routes on: peripheral values replace the latch on their pins, and
    // routed inputs follow the pins that the outside pulls low.
    task automatic t_route();
        tx = 1'b0;
        t0 = 1'b1;
        t1 = 1'b0;
        t2 = 1'b1;
        ext_low = 8'hAA;
        wr_sfr(SFR_ROUTE0, 8'hFF, 1'b0, 3'h0);
        rd_sfr(SFR_ROUTE0, 1'b0, rv);
        check("route", 8'hFD, rv);
        check("route out", 8'hFD, route);
        check("tx", {7'h0, tx}, {7'h0, pin_o[PIN_TX]});
        check("t0", {7'h0, t0}, {7'h0, pin_o[PIN_T0]});
        check("t1", {7'h0, t1}, {7'h0, pin_o[PIN_T1]});
        check("t2", {7'h0, t2}, {7'h0, pin_o[PIN_T2]});
        check("oe", 8'h11, pin_oe);
        repeat (3) @(negedge sys_clk_i);
        check("routed in", 8'h00, {4'h0, timer2_ext_input, irq1, rx, irq0});
        wr_sfr(SFR_ROUTE0, 8'h00, 1'b0, 3'h0);
        repeat (3) @(negedge sys_clk_i);
        check("route out", 8'h00, route);
        check("routed in", 8'h0F, {4'h0, timer2_ext_input, irq1, rx, irq0});
        rd_sfr(8'h00, 1'b0, rv);
        check("unmapped", 8'h00, rv);
        ext_low = 8'h00;
    endtask

    // Reset in mid-run returns every register to its reset value.
    task automatic t_mid_reset();
        wr_sfr(SFR_ROUTE0, 8'h01, 1'b0, 3'h0);
        wr_sfr(SFR_OUT_MODE0, 8'hFF, 1'b0, 3'h0);
        wr_sfr(SFR_PORT0, 8'h00, 1'b0, 3'h0);
        @(negedge sys_clk_i);
        arst_n_i = 1'b0;
        @(negedge sys_clk_i);
        check("route rst", ROUTE0_RESET, route);
        check("oe rst", 8'h00, pin_oe);
        arst_n_i = 1'b1;
        rd_sfr(SFR_PORT0, 1'b1, rv);
        check("latch rst", PORT0_RESET, rv);
        rd_sfr(SFR_OUT_MODE0, 1'b0, rv);
        check("mode rst", OUT_MODE_RESET, rv);
    endtask

    initial begin
        #250000;
        fails++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(negedge sys_clk_i);
        arst_n_i = 1'b1;
        t_reset();
        t_push();
        t_open();
        t_bits();
        t_route();
        t_mid_reset();
        tally_and_finish();
    end
endmodule // tb_port_io_latch_and_routing
